// >>> hw/led_matrix_control_regs.sv
`timescale 1ns/1ns
`default_nettype none
module led_matrix_control_regs #(
    parameter logic [6:0] DEV_ADDR_BASE = 7'h50,
    parameter int unsigned OSC_DIV = 4
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out_out,
    output logic sda_oe_out,
    input wire logic [1:0] addr_select_in,
    input wire logic clkio_in,
    output logic clkio_out_out,
    output logic clkio_oe_out,
    output logic oscillator_run_out,
    output logic soft_reset_out,
    output logic ghost_suppress_enable_out,
    output logic melody_input_select_out,
    output logic external_clock_select_out,
    output logic clock_output_enable_out,
    output logic led_clock_tick_out,
    output logic [2:0] max_current_select_out,
    output logic matrix_enable_out,
    output logic [7:0] pwm_enable_rows_ab_out,
    output logic [7:0] pwm_enable_rows_cd_out,
    output logic [7:0] melody_enable_rows_ab_out
);
    localparam int DIV_W = (OSC_DIV > 2) ? $clog2(OSC_DIV) : 1;

    // The divider needs at least two clocks per half period of the internal clock
    if (OSC_DIV < 2) begin : gen_div_check
        $error("OSC_DIV must be at least 2");
    end

    function automatic logic in_pattern(input logic [7:0] a);
        in_pattern = (a >= led_matrix_pkg::ADDR_PATTERN_FIRST) &&
                     (a <= led_matrix_pkg::ADDR_PATTERN_LAST);
    endfunction : in_pattern

    // Pin synchronisers; stage one feeds only stage two
    logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
    logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
    logic clkio_s1_ff, clkio_s2_ff, clkio_s3_ff;
    logic [1:0] sel_s1_ff, sel_s2_ff;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_s3_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_s3_ff <= 1'b1;
            clkio_s1_ff <= 1'b0;
            clkio_s2_ff <= 1'b0;
            clkio_s3_ff <= 1'b0;
            sel_s1_ff <= 2'h0;
            sel_s2_ff <= 2'h0;
        end else begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
            clkio_s1_ff <= clkio_in;
            clkio_s2_ff <= clkio_s1_ff;
            clkio_s3_ff <= clkio_s2_ff;
            sel_s1_ff <= addr_select_in;
            sel_s2_ff <= sel_s1_ff;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    logic [6:0] dev_addr;

    // Edges of the bus lines, seen only after synchronising
    assign scl_rise = scl_s2_ff & ~scl_s3_ff;
    assign scl_fall = ~scl_s2_ff & scl_s3_ff;
    assign start_det = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
    assign stop_det = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;
    assign dev_addr = DEV_ADDR_BASE | {5'h00, sel_s2_ff};

    // Link protocol state
    led_matrix_pkg::link_state_t state_ff, nxt_state;
    led_matrix_pkg::link_state_t ack_next_ff, nxt_ack_next;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] ptr_ff, nxt_ptr;
    logic sda_oe_ff, nxt_sda_oe;
    logic wr_stb;
    logic [7:0] rd_data;

    // One byte per frame byte: address, register pointer, then data
    always_comb begin
        nxt_state = state_ff;
        nxt_ack_next = ack_next_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_ptr = ptr_ff;
        nxt_sda_oe = sda_oe_ff;
        wr_stb = 1'b0;
        if (start_det) begin
            nxt_state = led_matrix_pkg::ST_ADDR;
            nxt_bit_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
        end else if (stop_det) begin
            nxt_state = led_matrix_pkg::ST_IDLE;
            nxt_sda_oe = 1'b0;
        end else begin
            unique case (state_ff)
                led_matrix_pkg::ST_IDLE: begin
                    nxt_sda_oe = 1'b0;
                end
                led_matrix_pkg::ST_ADDR, led_matrix_pkg::ST_REG,
                led_matrix_pkg::ST_WDATA: begin
                    if (scl_rise && bit_cnt_ff != led_matrix_pkg::BYTE_BITS) begin
                        nxt_shift = {shift_ff[6:0], sda_s2_ff};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == led_matrix_pkg::BYTE_BITS) begin
                        nxt_bit_cnt = 4'h0;
                        nxt_state = led_matrix_pkg::ST_ACK;
                        nxt_sda_oe = 1'b1;
                        if (state_ff == led_matrix_pkg::ST_ADDR) begin
                            // Foreign addresses are left alone until the next start
                            if (shift_ff[7:1] != dev_addr) begin
                                nxt_state = led_matrix_pkg::ST_IDLE;
                                nxt_sda_oe = 1'b0;
                            end else if (shift_ff[0]) begin
                                nxt_ack_next = led_matrix_pkg::ST_RDATA;
                            end else begin
                                nxt_ack_next = led_matrix_pkg::ST_REG;
                            end
                        end else if (state_ff == led_matrix_pkg::ST_REG) begin
                            nxt_ptr = shift_ff;
                            nxt_ack_next = led_matrix_pkg::ST_WDATA;
                        end else begin
                            wr_stb = 1'b1;
                            nxt_ptr = ptr_ff + 8'h01;
                            nxt_ack_next = led_matrix_pkg::ST_WDATA;
                        end
                    end
                end
                led_matrix_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        nxt_state = ack_next_ff;
                        nxt_bit_cnt = 4'h0;
                        nxt_sda_oe = 1'b0;
                        if (ack_next_ff == led_matrix_pkg::ST_RDATA) begin
                            nxt_shift = rd_data;
                            nxt_sda_oe = ~rd_data[7];
                            nxt_bit_cnt = 4'h1;
                            nxt_ptr = ptr_ff + 8'h01;
                        end
                    end
                end
                led_matrix_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_ff == led_matrix_pkg::BYTE_BITS) begin
                            nxt_state = led_matrix_pkg::ST_RACK;
                            nxt_sda_oe = 1'b0;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_sda_oe = ~shift_ff[6];
                            nxt_bit_cnt = bit_cnt_ff + 4'h1;
                        end
                    end
                end
                led_matrix_pkg::ST_RACK: begin
                    // Host acknowledge asks for the next byte, no acknowledge ends the read
                    if (scl_rise) begin
                        nxt_state = sda_s2_ff ? led_matrix_pkg::ST_IDLE
                                              : led_matrix_pkg::ST_ACK;
                        nxt_ack_next = led_matrix_pkg::ST_RDATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_ff <= led_matrix_pkg::ST_IDLE;
            ack_next_ff <= led_matrix_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            sda_oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ack_next_ff <= nxt_ack_next;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            ptr_ff <= nxt_ptr;
            sda_oe_ff <= nxt_sda_oe;
        end
    end

    // Open-drain data line: only ever pulled low
    assign sda_out_out = 1'b0;
    assign sda_oe_out = sda_oe_ff;

    // Control registers
    logic [7:0] reset_ctrl_ff, nxt_reset_ctrl;
    logic [7:0] power_ff, nxt_power;
    logic [7:0] option_ff, nxt_option;
    logic [7:0] matrix_ff, nxt_matrix;
    logic [7:0] pwm_ab_ff, nxt_pwm_ab;
    logic [7:0] pwm_cd_ff, nxt_pwm_cd;
    logic [7:0] melody_ab_ff, nxt_melody_ab;
    logic soft_reset;

    assign soft_reset = reset_ctrl_ff[led_matrix_pkg::BIT_SOFT_RESET];

    // Reset register is a one-cycle pulse; soft reset overrides a write in the same cycle
    always_comb begin
        nxt_reset_ctrl = led_matrix_pkg::RST_RESET_CONTROL;
        nxt_power = power_ff;
        nxt_option = option_ff;
        nxt_matrix = matrix_ff;
        nxt_pwm_ab = pwm_ab_ff;
        nxt_pwm_cd = pwm_cd_ff;
        nxt_melody_ab = melody_ab_ff;
        if (soft_reset) begin
            nxt_power = led_matrix_pkg::RST_POWER_CONTROL;
            nxt_option = led_matrix_pkg::RST_OPTION_SELECT;
            nxt_matrix = led_matrix_pkg::RST_MATRIX_ENABLE_CURRENT & led_matrix_pkg::MASK_MATRIX;
            nxt_pwm_ab = led_matrix_pkg::RST_PWM_ENABLE;
            nxt_pwm_cd = led_matrix_pkg::RST_PWM_ENABLE;
            nxt_melody_ab = led_matrix_pkg::RST_MELODY_ENABLE;
        end else if (wr_stb) begin
            unique case (ptr_ff)
                led_matrix_pkg::ADDR_RESET_CONTROL:
                    nxt_reset_ctrl = shift_ff & led_matrix_pkg::MASK_RESET_CONTROL;
                led_matrix_pkg::ADDR_POWER_CONTROL:
                    nxt_power = shift_ff & led_matrix_pkg::MASK_POWER_CONTROL;
                led_matrix_pkg::ADDR_OPTION_SELECT:
                    nxt_option = shift_ff & led_matrix_pkg::MASK_OPTION_SELECT;
                led_matrix_pkg::ADDR_MATRIX_ENABLE_CURRENT:
                    nxt_matrix = shift_ff & led_matrix_pkg::MASK_MATRIX;
                led_matrix_pkg::ADDR_PWM_ENABLE_ROWS_AB: nxt_pwm_ab = shift_ff;
                led_matrix_pkg::ADDR_PWM_ENABLE_ROWS_CD: nxt_pwm_cd = shift_ff;
                led_matrix_pkg::ADDR_MELODY_ENABLE_ROWS_AB: nxt_melody_ab = shift_ff;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reset_ctrl_ff <= led_matrix_pkg::RST_RESET_CONTROL;
            power_ff <= led_matrix_pkg::RST_POWER_CONTROL;
            option_ff <= led_matrix_pkg::RST_OPTION_SELECT;
            matrix_ff <= led_matrix_pkg::RST_MATRIX_ENABLE_CURRENT & led_matrix_pkg::MASK_MATRIX;
            pwm_ab_ff <= led_matrix_pkg::RST_PWM_ENABLE;
            pwm_cd_ff <= led_matrix_pkg::RST_PWM_ENABLE;
            melody_ab_ff <= led_matrix_pkg::RST_MELODY_ENABLE;
        end else begin
            reset_ctrl_ff <= nxt_reset_ctrl;
            power_ff <= nxt_power;
            option_ff <= nxt_option;
            matrix_ff <= nxt_matrix;
            pwm_ab_ff <= nxt_pwm_ab;
            pwm_cd_ff <= nxt_pwm_cd;
            melody_ab_ff <= nxt_melody_ab;
        end
    end

    // Duty and brightness bytes; soft reset also returns them to zero
    logic [7:0] pattern_rd;
    logic pattern_clear;

    assign pattern_clear = reset_ctrl_ff[led_matrix_pkg::BIT_PATTERN_CLEAR] | soft_reset;

    led_pattern_mem u_pattern (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(pattern_clear),
        .wr_en_in(wr_stb && in_pattern(ptr_ff)),
        .wr_addr_in(led_matrix_pkg::PATTERN_AW'(ptr_ff - led_matrix_pkg::ADDR_PATTERN_FIRST)),
        .wr_data_in(shift_ff),
        .rd_addr_in(led_matrix_pkg::PATTERN_AW'(ptr_ff - led_matrix_pkg::ADDR_PATTERN_FIRST)),
        .rd_data_out(pattern_rd)
    );

    // Read mux; unmapped and reserved offsets answer zero
    always_comb begin
        rd_data = 8'h00;
        unique case (ptr_ff)
            led_matrix_pkg::ADDR_RESET_CONTROL: rd_data = reset_ctrl_ff;
            led_matrix_pkg::ADDR_POWER_CONTROL: rd_data = power_ff;
            led_matrix_pkg::ADDR_OPTION_SELECT: rd_data = option_ff;
            led_matrix_pkg::ADDR_MATRIX_ENABLE_CURRENT:
                rd_data = matrix_ff | led_matrix_pkg::FIXED_MATRIX;
            led_matrix_pkg::ADDR_PWM_ENABLE_ROWS_AB: rd_data = pwm_ab_ff;
            led_matrix_pkg::ADDR_PWM_ENABLE_ROWS_CD: rd_data = pwm_cd_ff;
            led_matrix_pkg::ADDR_MELODY_ENABLE_ROWS_AB: rd_data = melody_ab_ff;
            default: begin
                if (in_pattern(ptr_ff)) begin
                    rd_data = pattern_rd;
                end
            end
        endcase
    end

    // Option decode: only the highest ranking clock or melody function acts
    logic ext_sel, clk_out_en, melody_sel, osc_run;

    assign ext_sel = option_ff[led_matrix_pkg::BIT_EXT_CLOCK];
    assign clk_out_en = option_ff[led_matrix_pkg::BIT_CLOCK_OUT] & ~ext_sel;
    assign melody_sel = option_ff[led_matrix_pkg::BIT_MELODY_INPUT] &
                        ~option_ff[led_matrix_pkg::BIT_CLOCK_OUT] & ~ext_sel;
    assign osc_run = power_ff[led_matrix_pkg::BIT_OSC_ENABLE] |
                     matrix_ff[led_matrix_pkg::BIT_MATRIX_ENABLE];

    // Internal oscillator model: a divider that stops when the oscillator is off
    logic [DIV_W-1:0] div_cnt_ff, nxt_div_cnt;
    logic int_clk_ff, nxt_int_clk;
    logic div_tick;

    always_comb begin
        div_tick = 1'b0;
        nxt_div_cnt = div_cnt_ff;
        nxt_int_clk = int_clk_ff;
        if (!osc_run) begin
            nxt_div_cnt = '0;
            nxt_int_clk = 1'b0;
        end else if (div_cnt_ff == DIV_W'(OSC_DIV - 1)) begin
            div_tick = 1'b1;
            nxt_div_cnt = '0;
            nxt_int_clk = ~int_clk_ff;
        end else begin
            nxt_div_cnt = div_cnt_ff + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            div_cnt_ff <= '0;
            int_clk_ff <= 1'b0;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
            int_clk_ff <= nxt_int_clk;
        end
    end

    // LED timebase follows the selected source: external rising edge or internal rising edge
    assign led_clock_tick_out = ext_sel ? (clkio_s2_ff & ~clkio_s3_ff)
                                        : (div_tick & ~int_clk_ff);
    assign clkio_out_out = int_clk_ff;
    assign clkio_oe_out = clk_out_en;

    assign oscillator_run_out = osc_run;
    assign soft_reset_out = soft_reset;
    assign ghost_suppress_enable_out = option_ff[led_matrix_pkg::BIT_GHOST_SUPPRESS];
    assign melody_input_select_out = melody_sel;
    assign external_clock_select_out = ext_sel;
    assign clock_output_enable_out = clk_out_en;
    assign max_current_select_out =
        matrix_ff[led_matrix_pkg::CURRENT_MSB:led_matrix_pkg::CURRENT_LSB];
    assign matrix_enable_out = matrix_ff[led_matrix_pkg::BIT_MATRIX_ENABLE];
    assign pwm_enable_rows_ab_out = pwm_ab_ff;
    assign pwm_enable_rows_cd_out = pwm_cd_ff;
    assign melody_enable_rows_ab_out = melody_ab_ff;
endmodule : led_matrix_control_regs
`default_nettype wire

// >>> hw/led_matrix_pkg.sv
`default_nettype none
package led_matrix_pkg;
    // Register offsets on the two-wire port
    localparam logic [7:0] ADDR_RESET_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_OPTION_SELECT = 8'h04;
    localparam logic [7:0] ADDR_MATRIX_ENABLE_CURRENT = 8'h05;
    localparam logic [7:0] ADDR_PWM_ENABLE_ROWS_AB = 8'h06;
    localparam logic [7:0] ADDR_PWM_ENABLE_ROWS_CD = 8'h07;
    localparam logic [7:0] ADDR_MELODY_ENABLE_ROWS_AB = 8'h08;
    localparam logic [7:0] ADDR_PATTERN_FIRST = 8'h10;
    localparam logic [7:0] ADDR_PATTERN_LAST = 8'h2F;

    // Reset values
    localparam logic [7:0] RST_RESET_CONTROL = 8'h00;
    localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
    localparam logic [7:0] RST_OPTION_SELECT = 8'h00;
    localparam logic [7:0] RST_MATRIX_ENABLE_CURRENT = 8'h1E;
    localparam logic [7:0] RST_PWM_ENABLE = 8'h00;
    localparam logic [7:0] RST_MELODY_ENABLE = 8'h00;

    // Writable bits of each register; the rest read zero, except matrix bit 4 (FIXED_MATRIX), which reads one
    localparam logic [7:0] MASK_RESET_CONTROL = 8'h03;
    localparam logic [7:0] MASK_POWER_CONTROL = 8'h01;
    localparam logic [7:0] MASK_OPTION_SELECT = 8'h0F;
    localparam logic [7:0] MASK_MATRIX = 8'h0F;
    localparam logic [7:0] FIXED_MATRIX = 8'h10;
    localparam logic [7:0] MASK_BRIGHTNESS = 8'hF7;

    // Field positions
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_PATTERN_CLEAR = 1;
    localparam int BIT_OSC_ENABLE = 0;
    localparam int BIT_EXT_CLOCK = 0;
    localparam int BIT_CLOCK_OUT = 1;
    localparam int BIT_MELODY_INPUT = 2;
    localparam int BIT_GHOST_SUPPRESS = 3;
    localparam int BIT_MATRIX_ENABLE = 0;
    localparam int CURRENT_LSB = 1;
    localparam int CURRENT_MSB = 3;

    // Pattern memory: duty bytes then brightness bytes
    localparam int PATTERN_DEPTH = 32;
    localparam int PATTERN_AW = 5;
    localparam logic [4:0] PATTERN_BRIGHT_FIRST = 5'h10;

    // Two-wire byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK
    } link_state_t;
endpackage : led_matrix_pkg
`default_nettype wire

// >>> hw/led_pattern_mem.sv
`timescale 1ns/1ns
`default_nettype none
module led_pattern_mem (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clear_in,
    input wire logic wr_en_in,
    input wire logic [led_matrix_pkg::PATTERN_AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [led_matrix_pkg::PATTERN_AW-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem_ff [led_matrix_pkg::PATTERN_DEPTH];
    logic [7:0] nxt_mem [led_matrix_pkg::PATTERN_DEPTH];

    // Clear wipes every duty and brightness byte at once, so no partial state is seen
    always_comb begin
        nxt_mem = mem_ff;
        if (clear_in) begin
            for (int i = 0; i < led_matrix_pkg::PATTERN_DEPTH; i++) begin
                nxt_mem[i] = 8'h00;
            end
        end else if (wr_en_in) begin
            if (wr_addr_in >= led_matrix_pkg::PATTERN_BRIGHT_FIRST) begin
                nxt_mem[wr_addr_in] = wr_data_in & led_matrix_pkg::MASK_BRIGHTNESS;
            end else begin
                nxt_mem[wr_addr_in] = wr_data_in;
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < led_matrix_pkg::PATTERN_DEPTH; i++) begin
                mem_ff[i] <= 8'h00;
            end
        end else begin
            mem_ff <= nxt_mem;
        end
    end

    // Read port feeds the link shift register, which registers it
    assign rd_data_out = mem_ff[rd_addr_in];
endmodule : led_pattern_mem
`default_nettype wire

// >>> test/led_matrix_control_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module led_matrix_control_regs_asserts #(
    parameter int OSC_DIV = 4
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic clkio_in,
    input wire logic sda_out_out,
    input wire logic sda_oe_out,
    input wire logic clkio_out_out,
    input wire logic clkio_oe_out,
    input wire logic oscillator_run_out,
    input wire logic soft_reset_out,
    input wire logic melody_input_select_out,
    input wire logic external_clock_select_out,
    input wire logic clock_output_enable_out,
    input wire logic led_clock_tick_out,
    input wire logic [2:0] max_current_select_out,
    input wire logic matrix_enable_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Option priority and clock routing
    osc_matrix_a: assert property (matrix_enable_out |-> oscillator_run_out)
        else $error("oscillator off while matrix on");
    melody_prio_a: assert property (
        melody_input_select_out |-> !external_clock_select_out && !clock_output_enable_out)
        else $error("melody input beat a higher option");
    clock_out_prio_a: assert property (
        clock_output_enable_out |-> !external_clock_select_out)
        else $error("clock output beat external clock");
    // Eight running cycles span a half period of the internal clock (OSC_DIV clocks) for dividers up to seven
    clock_drive_a: assert property (
        (clkio_oe_out && oscillator_run_out) [*8] |->
            clkio_out_out != $past(clkio_out_out, OSC_DIV))
        else $error("internal clock not driven out");
    ext_tick_a: assert property (
        $rose(clkio_in) && external_clock_select_out |-> ##[1:6] led_clock_tick_out)
        else $error("external clock edge gave no tick");
    // Soft reset is a single pulse that restores defaults
    soft_pulse_a: assert property (soft_reset_out |=> !soft_reset_out)
        else $error("soft reset stuck");
    soft_dflt_a: assert property (
        soft_reset_out |-> ##[0:2] (max_current_select_out == 3'h7 && !matrix_enable_out))
        else $error("soft reset left registers set");
    // Open drain data line only ever pulls low, and only moves while the host holds clock low
    sda_drain_a: assert property ($changed(sda_oe_out) |-> !scl_in && !sda_out_out)
        else $error("data line moved while clock high");
endmodule : led_matrix_control_regs_asserts
bind led_matrix_control_regs led_matrix_control_regs_asserts #(.OSC_DIV(OSC_DIV)) u_chk (
    .clk_in, .sys_rst_in, .scl_in, .clkio_in, .sda_out_out, .sda_oe_out, .clkio_out_out,
    .clkio_oe_out, .oscillator_run_out, .soft_reset_out, .melody_input_select_out,
    .external_clock_select_out, .clock_output_enable_out, .led_clock_tick_out,
    .max_current_select_out, .matrix_enable_out);
`default_nettype wire

// >>> test/i2c_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] DEV = 7'h51
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic pull_out
);
    int nacks = 0;
    initial begin
        scl_out = 1'b1;
        pull_out = 1'b0;
    end
    task automatic q(input int n);
        repeat (n) @(negedge clk_in);
    endtask : q
    // SCL period of ten clocks; data only moves while SCL is low
    task automatic bit_io(input logic v, output logic s);
        q(2);
        pull_out = !v;
        q(3);
        scl_out = 1'b1;
        q(3);
        s = sda_in;
        q(2);
        scl_out = 1'b0;
    endtask : bit_io
    // SDA moves while SCL is high: start when b is high, stop when low
    task automatic cond(input logic a, input logic b);
        q(2);
        pull_out = a;
        q(3);
        scl_out = 1'b1;
        q(5);
        pull_out = b;
        q(5);
    endtask : cond
    task automatic send(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        if (s !== 1'b0) nacks++;
    endtask : send
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cond(1'b0, 1'b1);
        scl_out = 1'b0;
        send({DEV, 1'b0});
        send(a);
        send(d);
        cond(1'b1, 1'b0);
    endtask : wr
    // Released SDA on the last acknowledge ends the read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic s;
        cond(1'b0, 1'b1);
        scl_out = 1'b0;
        send({DEV, 1'b0});
        send(a);
        cond(1'b0, 1'b1);
        scl_out = 1'b0;
        send({DEV, 1'b1});
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, s);
        cond(1'b1, 1'b0);
    endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// >>> test/led_matrix_control_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module led_matrix_control_regs_tb;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, clkio_in = 1'b0, scl, pull, sda_oe, run;
    logic ghost, mel, ext, clko, men;
    logic [2:0] cur;
    logic [7:0] d, pab, pcd, mab;
    wire sda;
    int bad_count = 0;
    int num_checks = 0;
    always #4 clk_in = ~clk_in;
    // Open drain with pull-up
    assign sda = !(pull || sda_oe);
    led_matrix_control_regs u_led_matrix_control_regs (.clk_in, .sys_rst_in, .scl_in(scl),
        .sda_in(sda), .sda_out_out(), .sda_oe_out(sda_oe), .addr_select_in(2'h1), .clkio_in,
        .clkio_out_out(), .clkio_oe_out(), .oscillator_run_out(run), .soft_reset_out(),
        .ghost_suppress_enable_out(ghost), .melody_input_select_out(mel),
        .external_clock_select_out(ext), .clock_output_enable_out(clko),
        .led_clock_tick_out(), .max_current_select_out(cur), .matrix_enable_out(men),
        .pwm_enable_rows_ab_out(pab), .pwm_enable_rows_cd_out(pcd),
        .melody_enable_rows_ab_out(mab));
    i2c_host_model u_host (.clk_in, .sda_in(sda), .scl_out(scl), .pull_out(pull));
    task rchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, d);
        `CHK(d, e)
    endtask : rchk
    task t_regs;
        rchk(8'h05, 8'h1E);
        `CHK(cur, 3'h7)
        u_host.wr(8'h02, 8'hFF);
        rchk(8'h02, 8'h01);
        `CHK(run, 1'b1)
        u_host.wr(8'h02, 8'h00);
        u_host.wr(8'h05, 8'hE7);
        rchk(8'h05, 8'h17);
        `CHK({run, men, cur}, 5'h1B)
        u_host.wr(8'h05, 8'h00);
        `CHK({run, men}, 2'h0)
        u_host.wr(8'h03, 8'hFF);
        rchk(8'h03, 8'h00);
        $display("register test done");
    endtask : t_regs
    task t_option;
        logic [3:0] o;
        // Oscillator on, so the clock output pin carries a live clock
        u_host.wr(8'h02, 8'h01);
        for (int i = 0; i < 16; i++) begin
            o = 4'(i);
            u_host.wr(8'h04, {4'h0, o});
            rchk(8'h04, {4'h0, o});
            `CHK({ghost, ext}, {o[3], o[0]})
            `CHK(clko, o[1] & !o[0])
            `CHK(mel, o[2] & !o[1] & !o[0])
            // Run the external clock so its ticks are watched
            for (int k = 0; k < 4 && o[0]; k++) begin
                repeat (5) @(negedge clk_in);
                clkio_in = ~clkio_in;
            end
        end
        $display("option test done");
    endtask : t_option
    task t_leds;
        u_host.wr(8'h06, 8'hA5);
        u_host.wr(8'h07, 8'h5A);
        u_host.wr(8'h08, 8'h3C);
        `CHK({pab, pcd, mab}, 24'hA55A3C)
        rchk(8'h07, 8'h5A);
        $display("led enable test done");
    endtask : t_leds
    task t_clear;
        u_host.wr(8'h10, 8'hAB);
        u_host.wr(8'h2F, 8'hFF);
        rchk(8'h2F, 8'hF7);
        rchk(8'h10, 8'hAB);
        u_host.wr(8'h01, 8'h02);
        rchk(8'h01, 8'h00);
        rchk(8'h10, 8'h00);
        rchk(8'h2F, 8'h00);
        `CHK(pab, 8'hA5)
        u_host.wr(8'h01, 8'h01);
        `CHK({pab, ext, cur}, 12'h007)
        rchk(8'h04, 8'h00);
        `CHK(u_host.nacks, 0)
        $display("reset register test done");
    endtask : t_clear
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // Watchdog: the tests need about 20,000 clocks, so allow two and a half times that
    initial begin
        #400000;
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (20) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        t_regs;
        t_option;
        t_leds;
        t_clear;
        finish_test;
    end
endmodule : led_matrix_control_regs_tb
`default_nettype wire
